// ==== src/dpll_ctrl_defines.svh ====
// Offsets, field positions, reset values and timing figures of the block.
`ifndef DPLL_CTRL_DEFINES_SVH
`define DPLL_CTRL_DEFINES_SVH

// Register byte offsets on the APB port.
`define OFS_STATUS 12'h000
`define OFS_FREERUN_WORD 12'h004
`define OFS_HOLD_WORD 12'h008
`define OFS_PERIOD 12'h00c

// Field positions inside the status register.
`define STS_STATE_LSB 0
`define STS_LOCKED 4
`define STS_VALID 5
`define STS_ACTIVE_SEL 6
`define STS_CANCEL_EN 7
`define STS_FLAG_LSB 8
`define STS_RATE_LSB 12

// Reset values.
`define FREERUN_WORD_RST 16'h1000
`define HOLD_WORD_RST 16'h0000

// Operating mode pin codes, high bit first.
`define MODE_NORMAL 2'h0
`define MODE_HOLDOVER 2'h1
`define MODE_FREERUN 2'h2

// Reference rate codes.
`define RATE_19M44 2'h0
`define RATE_8K 2'h1
`define RATE_1M544 2'h2
`define RATE_2M048 2'h3

// Clock and reference rates in hertz, clock period in nanoseconds.
`define CLK_HZ 200000000
`define CLK_PERIOD_NS 5
`define HZ_19M44 19440000
`define HZ_8K 8000
`define HZ_1M544 1544000
`define HZ_2M048 2048000

// Timing figures in their own units.
`define FRAME_PERIOD_NS 125000
`define FRAME_HIGH_NS 122
`define STORE_PERIOD_MS 30
`define LOCK_SLOW_S 30
`define LOCK_FAST_MS 500
`define MON_GATE_S 2
`define MON_PPM 12

`endif

// ==== src/dpll_ctrl_pkg.sv ====
// Types shared by the mode and reference control block and its bench.
package dpll_ctrl_pkg;

   // Operating states of the state control circuit.
   typedef enum logic [2:0] {
      st_freerun,
      st_normal,
      st_auto_hold,
      st_holdover,
      st_short_hold
   } state_e;

   // APB request from the bus master.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   // APB answer from this slave.
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   // Mode status pins.
   typedef struct packed {
      logic normal;
      logic holdover;
      logic freerun;
   } mode_status_s;

endpackage

// ==== src/dpll_mode_and_reference_control.sv ====
// Mode state control, reference selection and monitoring of the DPLL.
`timescale 1ns/1ps
`include "dpll_ctrl_defines.svh"

// Operation
// - State changes only at frame pulse rising edge.
// - Mode pins: 00 normal, 01 holdover, 10 freerun.
// - Normal with invalid reference enters auto holdover.
// - Auto holdover returns normal when reference valid.
// - Selector change in auto holdover: short holdover.
// - Selector change in normal: short holdover.
// - Quiet selector ends short holdover on new input.
// - Transitions disable canceller except holdovers into normal.
// - Normal status high only in normal.
// - Holdover status high only in holdover.
// - Freerun status high only in freerun.
// - Lock to reference within thirty seconds.
// - Fast acquire input selects fast lock submode.
// - Store word each 30 ms, two slots alternating.
// - Freerun uses oscillator only, references ignored.
// - Per input two-bit rate select decode.
// - Rate selection takes effect only through reset.
// - Falling edge used, rising at 19.44 MHz.
// - Selector low picks input a, high b.
// - Per input offset flag beyond 12 ppm, 2 s.
// - Reference outside capture range counts as invalid.
module dpll_mode_and_reference_control
   import dpll_ctrl_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES =
      `FRAME_PERIOD_NS / `CLK_PERIOD_NS,
   parameter int unsigned STORE_CYCLES =
      `STORE_PERIOD_MS * 1000000 / `CLK_PERIOD_NS,
   parameter longint unsigned LOCK_SLOW_CYCLES =
      longint'(`LOCK_SLOW_S) * 64'd1000000000 / `CLK_PERIOD_NS,
   parameter int unsigned LOCK_FAST_CYCLES =
      `LOCK_FAST_MS * 1000000 / `CLK_PERIOD_NS,
   parameter int unsigned MON_GATE_CYCLES =
      `MON_GATE_S * 1000000000 / `CLK_PERIOD_NS
) (
   input logic core_clk, // 200 MHz clock, also the master oscillator.
   input logic rst_n, // Synchronous reset, active low.
   input logic clk_en, // Freezes all state while low, unless rst_n is low.
   input apb_req_s apb_req, // APB request.
   output apb_rsp_s apb_rsp, // APB answer.
   input logic op_select_hi, // Mode select, high bit.
   input logic op_select_lo, // Mode select, low bit.
   input logic in_select, // Reference selector, 0 is input a.
   input logic phase_hit_cancel_enable, // Canceller enable pin.
   input logic fast_acquire_in, // Fast lock request.
   input logic ref0_rate_hi, // Input a rate, high bit.
   input logic ref0_rate_lo, // Input a rate, low bit.
   input logic ref1_rate_hi, // Input b rate, high bit.
   input logic ref1_rate_lo, // Input b rate, low bit.
   input logic reference_in_a, // Reference input a.
   input logic reference_in_b, // Reference input b.
   output logic frame_pulse_8k_out, // 8 kHz frame pulse, active high.
   output mode_status_s mode_status, // Normal, holdover, freerun.
   output logic phase_hit_canceller_on, // Canceller enable to the loop.
   output logic limiter_bypass, // Fast lock submode active.
   output logic lock_indicator, // Loop considered locked.
   output logic selected_ref, // Reference in use, 0 is input a.
   output logic [15:0] dco_word, // Frequency word for the oscillator.
   output logic ref_a_offset_flag, // Input a off nominal.
   output logic ref_b_offset_flag // Input b off nominal.
);

   ////////////////////////////////////////////////////////////////////////
   // Derived constants.

   localparam int unsigned FRAME_HIGH = `FRAME_HIGH_NS / `CLK_PERIOD_NS;

   // Nominal reference rate for a rate code.
   function automatic longint rate_hz(input logic [1:0] code);
      longint r;
      r = `HZ_19M44;
      if (code == `RATE_8K) begin
         r = `HZ_8K;
      end else if (code == `RATE_1M544) begin
         r = `HZ_1M544;
      end else if (code == `RATE_2M048) begin
         r = `HZ_2M048;
      end
      return r;
   endfunction

   // Nominal reference period in clock cycles.
   function automatic logic [15:0] nom_period(input logic [1:0] code);
      return 16'(longint'(`CLK_HZ) / rate_hz(code));
   endfunction

   // Edges expected in one monitor gate.
   function automatic logic [25:0] exp_count(input logic [1:0] code);
      return 26'(rate_hz(code) * longint'(MON_GATE_CYCLES) / `CLK_HZ);
   endfunction

   // Allowed deviation from the expected edge count.
   function automatic logic [25:0] tol_count(input logic [1:0] code);
      return 26'(longint'(exp_count(code)) * `MON_PPM / 1000000);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      state_e state;
      logic sel_prev;
      logic active_sel;
      logic cancel_en;
      logic [1:0] ref_prev;
      logic [1:0][1:0] rate;
      logic [31:0] frame_cnt;
      logic frame_out;
      logic [15:0] gap_cnt;
      logic [15:0] period;
      logic ref_valid;
      logic [33:0] lock_cnt;
      logic locked;
      logic fast;
      logic [31:0] store_cnt;
      logic [1:0][15:0] slot;
      logic last_slot;
      logic [15:0] hold_word;
      logic [15:0] dco;
      logic [15:0] freerun_word;
      logic [31:0] gate_cnt;
      logic [1:0][25:0] edge_cnt;
      logic [1:0] offset_flag;
      mode_status_s status;
      apb_rsp_s rsp;
   } ctrl_s;

   ctrl_s st;
   ctrl_s next_st;
   logic [1:0] ref_now;
   logic [1:0] ref_edge;

   assign ref_now = {reference_in_b, reference_in_a};

   ////////////////////////////////////////////////////////////////////////
   // Edge sense per input; 19.44 MHz uses rising edges for timing.

   for (genvar i = 0; i < 2; i++) begin : g_edge
      assign ref_edge[i] = (st.rate[i] == `RATE_19M44) ?
         (ref_now[i] & ~st.ref_prev[i]) :
         (~ref_now[i] & st.ref_prev[i]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for everything the block remembers.

   always_comb begin
      logic frame_rise;
      logic sel_now;
      logic transient;
      logic sel_edge;
      logic [1:0] mode;
      logic [1:0] arate;
      logic [15:0] nom;
      logic [15:0] meas;
      logic [25:0] dev;
      logic [33:0] lock_target;
      logic apb_access;
      logic [31:0] rdata;
      logic addr_ok;
      state_e tgt;
      frame_rise = 1'b0;
      sel_now = 1'b0;
      transient = 1'b0;
      sel_edge = 1'b0;
      mode = 2'h0;
      arate = 2'h0;
      nom = 16'h0000;
      meas = 16'h0000;
      dev = 26'h0000000;
      lock_target = 34'h000000000;
      apb_access = 1'b0;
      rdata = 32'h00000000;
      addr_ok = 1'b0;
      tgt = st.state;
      next_st = st;

      // Internal frame pulse; its rising edge paces every state change.
      if (st.frame_cnt >= 32'(FRAME_CYCLES - 1)) begin
         next_st.frame_cnt = 32'h00000000;
         frame_rise = 1'b1;
      end else begin
         next_st.frame_cnt = st.frame_cnt + 32'h00000001;
      end
      next_st.frame_out = (next_st.frame_cnt < 32'(FRAME_HIGH));
      next_st.ref_prev = ref_now;

      // Period measure and validity of the reference in use.
      arate = st.rate[st.active_sel];
      sel_edge = ref_edge[st.active_sel];
      nom = nom_period(arate);
      meas = st.gap_cnt + 16'h0001;
      if (st.state == st_freerun) begin
         // References are ignored; the word comes from the oscillator.
         next_st.gap_cnt = 16'h0000;
         next_st.ref_valid = 1'b0;
      end else if (sel_edge) begin
         next_st.gap_cnt = 16'h0000;
         next_st.period = meas;
         // Too short or too long a period is out of capture range.
         next_st.ref_valid = (meas >= (nom >> 1)) &&
            (meas <= (nom << 1));
      end else begin
         if (st.gap_cnt != 16'hffff) begin
            next_st.gap_cnt = meas;
         end
         if (st.gap_cnt >= (nom << 1)) begin
            next_st.ref_valid = 1'b0;
         end
      end

      // Lock timer; fast acquire shortens the wait.
      next_st.fast = fast_acquire_in && (st.state == st_normal);
      lock_target = fast_acquire_in ? 34'(LOCK_FAST_CYCLES) :
         34'(LOCK_SLOW_CYCLES);
      if ((st.state == st_normal) && st.ref_valid) begin
         if (st.lock_cnt < lock_target) begin
            next_st.lock_cnt = st.lock_cnt + 34'h000000001;
         end
         next_st.locked = (st.lock_cnt >= lock_target);
      end else begin
         next_st.lock_cnt = 34'h000000000;
         next_st.locked = 1'b0;
      end

      // Holdover storage: two slots written in turn while locked.
      if ((st.state == st_normal) && st.locked) begin
         if (st.store_cnt >= 32'(STORE_CYCLES - 1)) begin
            next_st.store_cnt = 32'h00000000;
            next_st.slot[~st.last_slot] = st.period;
            next_st.last_slot = ~st.last_slot;
         end else begin
            next_st.store_cnt = st.store_cnt + 32'h00000001;
         end
      end else begin
         next_st.store_cnt = 32'h00000000;
      end

      // State control at the frame pulse.
      if (frame_rise) begin
         sel_now = in_select;
         transient = (sel_now != st.sel_prev);
         next_st.sel_prev = sel_now;
         mode = {op_select_hi, op_select_lo};
         case (st.state)
            st_freerun: begin
               // Holdover straight after reset has no stored word.
               if (mode == `MODE_NORMAL) begin
                  tgt = st_normal;
               end
            end
            st_normal: begin
               if (transient) begin
                  tgt = st_short_hold;
               end else if (!st.ref_valid) begin
                  tgt = st_auto_hold;
               end else if (mode == `MODE_HOLDOVER) begin
                  tgt = st_holdover;
               end else if (mode == `MODE_FREERUN) begin
                  tgt = st_freerun;
               end
            end
            st_auto_hold: begin
               if (transient) begin
                  tgt = st_short_hold;
               end else if (mode == `MODE_HOLDOVER) begin
                  tgt = st_holdover;
               end else if (mode == `MODE_FREERUN) begin
                  tgt = st_freerun;
               end else if (st.ref_valid) begin
                  tgt = st_normal;
               end
            end
            st_holdover: begin
               if (mode == `MODE_NORMAL) begin
                  tgt = st_normal;
               end else if (mode == `MODE_FREERUN) begin
                  tgt = st_freerun;
               end
            end
            st_short_hold: begin
               if (!transient) begin
                  tgt = st_normal;
                  next_st.active_sel = sel_now;
               end
            end
            default: begin
               tgt = st_freerun;
            end
         endcase
         if (tgt != st.state) begin
            next_st.state = tgt;
            // Only a return to normal from a holdover follows the pin.
            next_st.cancel_en = (tgt == st_normal) &&
               (st.state != st_freerun) && phase_hit_cancel_enable;
            if ((st.state == st_normal) && (tgt != st_freerun)) begin
               // The older slot is 30 ms to 60 ms old.
               next_st.hold_word = st.slot[~st.last_slot];
            end
         end
      end

      // Status pins follow the state being entered.
      next_st.status.normal = (next_st.state == st_normal);
      next_st.status.holdover = (next_st.state == st_holdover) ||
         (next_st.state == st_auto_hold) ||
         (next_st.state == st_short_hold);
      next_st.status.freerun = (next_st.state == st_freerun);

      // Frequency word handed to the oscillator.
      if (next_st.state == st_freerun) begin
         next_st.dco = st.freerun_word;
      end else if (next_st.state == st_normal) begin
         next_st.dco = st.period;
      end else begin
         next_st.dco = next_st.hold_word;
      end

      // Offset monitors on both inputs, refreshed once per gate.
      for (int i = 0; i < 2; i++) begin
         if (ref_edge[i] && (st.edge_cnt[i] != 26'h3ffffff)) begin
            next_st.edge_cnt[i] = st.edge_cnt[i] + 26'h0000001;
         end
      end
      if (st.gate_cnt >= 32'(MON_GATE_CYCLES - 1)) begin
         next_st.gate_cnt = 32'h00000000;
         for (int i = 0; i < 2; i++) begin
            dev = (st.edge_cnt[i] > exp_count(st.rate[i])) ?
               st.edge_cnt[i] - exp_count(st.rate[i]) :
               exp_count(st.rate[i]) - st.edge_cnt[i];
            next_st.offset_flag[i] = (dev > tol_count(st.rate[i]));
            next_st.edge_cnt[i] = 26'h0000000;
         end
      end else begin
         next_st.gate_cnt = st.gate_cnt + 32'h00000001;
      end

      // APB slave: one wait cycle, then a registered answer.
      apb_access = apb_req.psel && apb_req.penable;
      addr_ok = 1'b1;
      if (apb_req.paddr == `OFS_STATUS) begin
         rdata[`STS_STATE_LSB +: 3] = st.state;
         rdata[`STS_LOCKED] = st.locked;
         rdata[`STS_VALID] = st.ref_valid;
         rdata[`STS_ACTIVE_SEL] = st.active_sel;
         rdata[`STS_CANCEL_EN] = st.cancel_en;
         rdata[`STS_FLAG_LSB +: 2] = st.offset_flag;
         rdata[`STS_RATE_LSB +: 4] = st.rate;
      end else if (apb_req.paddr == `OFS_FREERUN_WORD) begin
         rdata[15:0] = st.freerun_word;
      end else if (apb_req.paddr == `OFS_HOLD_WORD) begin
         rdata[15:0] = st.hold_word;
      end else if (apb_req.paddr == `OFS_PERIOD) begin
         rdata[15:0] = st.period;
      end else begin
         addr_ok = 1'b0;
      end
      if (apb_access && st.rsp.pready) begin
         // The write lands on the edge where the master sees pready.
         if (apb_req.pwrite && (apb_req.paddr == `OFS_FREERUN_WORD)) begin
            next_st.freerun_word = apb_req.pwdata[15:0];
         end
         next_st.rsp = '0;
      end else if (apb_access) begin
         next_st.rsp.pready = 1'b1;
         next_st.rsp.pslverr = !addr_ok;
         next_st.rsp.prdata = (apb_req.pwrite || !addr_ok) ?
            32'h00000000 : rdata;
      end else begin
         next_st.rsp = '0;
      end

      // Reset: freerun, and the rate pins are captured only here.
      if (!rst_n) begin
         next_st = '0;
         next_st.state = st_freerun;
         next_st.status.freerun = 1'b1;
         next_st.rate[0] = {ref0_rate_hi, ref0_rate_lo};
         next_st.rate[1] = {ref1_rate_hi, ref1_rate_lo};
         next_st.ref_prev = ref_now;
         next_st.frame_out = 1'b1;
         next_st.freerun_word = `FREERUN_WORD_RST;
         next_st.hold_word = `HOLD_WORD_RST;
         next_st.dco = `FREERUN_WORD_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset wins over the clock enable.

   always_ff @(posedge core_clk) begin
      if (clk_en || !rst_n) begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign apb_rsp = st.rsp;
   assign frame_pulse_8k_out = st.frame_out;
   assign mode_status = st.status;
   assign phase_hit_canceller_on = st.cancel_en;
   assign limiter_bypass = st.fast;
   assign lock_indicator = st.locked;
   assign selected_ref = st.active_sel;
   assign dco_word = st.dco;
   assign ref_a_offset_flag = st.offset_flag[0];
   assign ref_b_offset_flag = st.offset_flag[1];

endmodule

// ==== verification/dpll_ctrl_checker.sv ====
// Concurrent checks on the mode and reference control block ports.
`timescale 1ns/1ps
module dpll_ctrl_checker
   import dpll_ctrl_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES = 25000
) (
   input logic core_clk, // Clock.
   input logic rst_n, // Reset, active low.
   input logic op_select_hi, // Mode select, high bit.
   input logic op_select_lo, // Mode select, low bit.
   input logic in_select, // Reference selector.
   input logic phase_hit_cancel_enable, // Canceller pin.
   input logic frame_pulse_8k_out, // Frame pulse.
   input mode_status_s mode_status, // Status pins.
   input logic phase_hit_canceller_on, // Canceller to the loop.
   input logic selected_ref // Reference in use.
);
   logic fp_d, sel_d, sel_frm, seen;
   logic [1:0] pins_d;
   mode_status_s ms_d;
   int unsigned gap;
   wire frame_edge = frame_pulse_8k_out & ~fp_d;

   // Delayed copies line up the inputs the design saw at a frame edge.
   always_ff @(posedge core_clk) begin
      fp_d <= frame_pulse_8k_out;
      sel_d <= in_select;
      pins_d <= {op_select_hi, op_select_lo};
      ms_d <= mode_status;
      if (!rst_n) begin
         seen <= 1'b0;
         gap <= 0;
         sel_frm <= in_select;
      end else if (frame_edge) begin
         seen <= 1'b1;
         gap <= 1;
         sel_frm <= sel_d;
      end else begin
         gap <= gap + 1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   property p_state_at_frame;
      !$stable(mode_status) |-> frame_edge;
   endproperty
   a_state_at_frame: assert property (p_state_at_frame)
      else $error("Mode status moved off a frame edge.");
   property p_frame_period;
      frame_edge && seen |-> gap == FRAME_CYCLES;
   endproperty
   a_frame_period: assert property (p_frame_period)
      else $error("Frame pulse period is wrong.");
   property p_one_hot;
      $onehot(mode_status);
   endproperty
   a_one_hot: assert property (p_one_hot)
      else $error("Status pins are not one-hot.");
   property p_hold_pins;
      frame_edge && pins_d == 2'h1 && !ms_d.freerun |-> mode_status.holdover;
   endproperty
   a_hold_pins: assert property (p_hold_pins)
      else $error("Holdover pins did not give holdover.");
   property p_free_pins;
      frame_edge && pins_d == 2'h2 && !ms_d.holdover |-> mode_status.freerun;
   endproperty
   a_free_pins: assert property (p_free_pins)
      else $error("Freerun pins did not give freerun.");
   property p_sel_short;
      frame_edge && ms_d.normal && pins_d == 2'h0 && sel_d != sel_frm
         |-> mode_status.holdover && !phase_hit_canceller_on;
   endproperty
   a_sel_short: assert property (p_sel_short)
      else $error("Selector change did not leave normal.");
   property p_canc_off;
      !mode_status.normal |-> !phase_hit_canceller_on;
   endproperty
   a_canc_off: assert property (p_canc_off)
      else $error("Canceller on outside normal.");
   property p_canc_pin;
      frame_edge && mode_status.normal && ms_d.holdover
         |-> phase_hit_canceller_on == $past(phase_hit_cancel_enable);
   endproperty
   a_canc_pin: assert property (p_canc_pin)
      else $error("Canceller does not follow its pin.");
   property p_free_norm;
      frame_edge && mode_status.normal && ms_d.freerun
         |-> !phase_hit_canceller_on;
   endproperty
   a_free_norm: assert property (p_free_norm)
      else $error("Canceller on after freerun.");
   property p_ref_at_frame;
      !$stable(selected_ref) |-> frame_edge && mode_status.normal;
   endproperty
   a_ref_at_frame: assert property (p_ref_at_frame)
      else $error("Reference switched off a frame edge.");
endmodule

bind dpll_mode_and_reference_control dpll_ctrl_checker #(
   .FRAME_CYCLES(FRAME_CYCLES)
) chk (
   .core_clk(core_clk), .rst_n(rst_n), .op_select_hi(op_select_hi),
   .op_select_lo(op_select_lo), .in_select(in_select),
   .phase_hit_cancel_enable(phase_hit_cancel_enable),
   .frame_pulse_8k_out(frame_pulse_8k_out), .mode_status(mode_status),
   .phase_hit_canceller_on(phase_hit_canceller_on),
   .selected_ref(selected_ref)
);

// ==== verification/dpll_mode_and_reference_control_test.sv ====
// Self-checking bench for the mode and reference control block.
`timescale 1ns/1ps
`include "dpll_ctrl_defines.svh"
module dpll_mode_and_reference_control_test
   import dpll_ctrl_pkg::*;
;
   localparam int FRAME = 200;
   logic core_clk, rst_n, clk_en, in_select, phase_hit_cancel_enable;
   logic op_select_hi, op_select_lo, fast_acquire_in, run_a, run_b;
   logic ref0_rate_hi, ref0_rate_lo, ref1_rate_hi, ref1_rate_lo;
   logic reference_in_a, reference_in_b, frame_pulse_8k_out;
   logic phase_hit_canceller_on, limiter_bypass, lock_indicator;
   logic selected_ref, ref_a_offset_flag, ref_b_offset_flag, er;
   logic [15:0] dco_word;
   logic [31:0] rd;
   apb_req_s apb_req;
   apb_rsp_s apb_rsp;
   mode_status_s mode_status;
   int err_total = 0, num_checks = 0;

   dpll_mode_and_reference_control #(
      .FRAME_CYCLES(200), .STORE_CYCLES(20), .LOCK_SLOW_CYCLES(300),
      .LOCK_FAST_CYCLES(100), .MON_GATE_CYCLES(20000)
   ) dut (
      .core_clk, .rst_n, .clk_en, .apb_req, .apb_rsp, .op_select_hi,
      .op_select_lo, .in_select, .phase_hit_cancel_enable,
      .fast_acquire_in, .ref0_rate_hi, .ref0_rate_lo, .ref1_rate_hi,
      .ref1_rate_lo, .reference_in_a, .reference_in_b,
      .frame_pulse_8k_out, .mode_status, .phase_hit_canceller_on,
      .limiter_bypass, .lock_indicator, .selected_ref, .dco_word,
      .ref_a_offset_flag, .ref_b_offset_flag
   );

   ref_source_model src (
      .core_clk, .run_a, .run_b,
      .ref_a(reference_in_a), .ref_b(reference_in_b)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Prints the verdict and ends the run.
   task automatic test_done();
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   // One APB transfer; the wait for pready is bounded, not assumed.
   task automatic apb(input logic wr, input logic [11:0] addr,
         input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                   pwdata: wd};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (apb_rsp.pready !== 1'b1) begin
         err_total++;
         test_done();
      end
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Waits for k frame pulse rises; returns with that edge's state settled.
   task automatic frames(input int k);
      int n;
      logic prev;
      repeat (k) begin
         n = 0;
         do begin
            prev = frame_pulse_8k_out;
            @(posedge core_clk);
            n++;
         end while (!(frame_pulse_8k_out === 1'b1 && prev === 1'b0) &&
                    n < 3 * FRAME);
         if (n >= 3 * FRAME) begin
            err_total++;
            test_done();
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      apb_req = '0;
      {op_select_hi, op_select_lo} = 2'h2;
      {ref0_rate_hi, ref0_rate_lo, ref1_rate_hi, ref1_rate_lo} = 4'hc;
      {in_select, fast_acquire_in} = 2'h0;
      phase_hit_cancel_enable = 1'b1;
      {run_a, run_b} = 2'h3;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      check(mode_status, 3'h1);
      check(dco_word, 16'h1000);
      apb(1'b0, `OFS_STATUS, 32'h0);
      check(rd[15:12], 4'h3);
      apb(1'b1, `OFS_FREERUN_WORD, 32'h0000_1234);
      apb(1'b0, 12'h010, 32'h0);
      check({er, rd}, 33'h1_0000_0000);
      frames(1);
      check(dco_word, 16'h1234);
      // Freerun to normal must leave the canceller off despite its pin.
      {op_select_hi, op_select_lo} <= 2'h0;
      frames(1);
      check({mode_status, phase_hit_canceller_on}, 4'h8);
      check(selected_ref, 1'b0);
      fast_acquire_in <= 1'b1;
      frames(2);
      check({limiter_bypass, lock_indicator}, 2'h3);
      fast_acquire_in <= 1'b0;
      frames(1);
      check(limiter_bypass, 1'b0);
      // Selector flip: one frame of short holdover, then the new input.
      in_select <= 1'b1;
      frames(1);
      check({mode_status, phase_hit_canceller_on}, 4'h4);
      frames(1);
      check({mode_status, phase_hit_canceller_on}, 4'h9);
      check(selected_ref, 1'b1);
      run_b <= 1'b0;
      frames(2);
      check({mode_status, phase_hit_canceller_on}, 4'h4);
      run_b <= 1'b1;
      phase_hit_cancel_enable <= 1'b0;
      frames(3);
      check({mode_status, phase_hit_canceller_on}, 4'h8);
      run_b <= 1'b0;
      frames(2);
      in_select <= 1'b0;
      frames(1);
      check({mode_status, phase_hit_canceller_on}, 4'h4);
      frames(1);
      check({mode_status, selected_ref}, 4'h8);
      {op_select_hi, op_select_lo} <= 2'h1;
      frames(1);
      check({mode_status, phase_hit_canceller_on}, 4'h4);
      check(dco_word, 16'(`CLK_HZ / `HZ_19M44));
      {op_select_hi, op_select_lo} <= 2'h3;
      frames(1);
      check(mode_status, 3'h2);
      {op_select_hi, op_select_lo} <= 2'h2;
      frames(1);
      check(mode_status, 3'h1);
      check(dco_word, 16'h1234);
      // Whole-cycle periods are off nominal, so both monitors must trip.
      run_b <= 1'b1;
      repeat (45000) @(posedge core_clk);
      check({ref_a_offset_flag, ref_b_offset_flag}, 2'h3);
      {ref0_rate_hi, ref0_rate_lo} <= 2'h1;
      apb(1'b0, `OFS_STATUS, 32'h0);
      check(rd[15:12], 4'h3);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, `OFS_STATUS, 32'h0);
      check(rd[15:12], 4'h1);
      check({mode_status, dco_word}, {3'h1, 16'h1000});
      test_done();
   end
endmodule

// ==== verification/ref_source_model.sv ====
// Behavioural network reference sources for the two reference inputs.
`timescale 1ns/1ps
module ref_source_model #(
   parameter int PER_A = 97,
   parameter int PER_B = 10
) (
   input logic core_clk, // Clock the sources are timed from.
   input logic run_a, // Source a running.
   input logic run_b, // Source b running.
   output logic ref_a, // Reference a.
   output logic ref_b // Reference b.
);
   int cnt_a = 0;
   int cnt_b = 0;

   // A stopped source freezes its line, which is how a lost reference
   // looks at the pin; periods are whole cycles, so never exactly nominal.
   always @(posedge core_clk) begin
      if (run_a) begin
         cnt_a <= (cnt_a >= PER_A - 1) ? 0 : cnt_a + 1;
         ref_a <= (cnt_a < PER_A / 2);
      end
      if (run_b) begin
         cnt_b <= (cnt_b >= PER_B - 1) ? 0 : cnt_b + 1;
         ref_b <= (cnt_b < PER_B / 2);
      end
   end
endmodule
